// >>> rtl/ofd_pkg.sv
// Constants and types for the operand field decoder.
// Assumes one core clock shared with the fetch path.
package ofd_pkg;

  // ----------------------------------------------------------------
  // Opcodes and field encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] OFD_OPC_ADD_RR = 8'h04;
  localparam logic [3:0] OFD_ESC_NIBBLE = 4'hE;
  localparam logic [7:0] OFD_RESET_BYTE = 8'h00;
  localparam logic [11:0] OFD_RESET_ADDR12 = 12'h000;
  localparam logic [15:0] OFD_RESET_ADDR16 = 16'h0000;
  localparam logic [3:0] OFD_RESET_NIB = 4'h0;
  localparam logic [2:0] OFD_RESET_BIT = 3'h0;
  localparam logic [1:0] OFD_LEN_ZERO = 2'h0;
  localparam logic [1:0] OFD_LEN_TWO = 2'h2;

  // ----------------------------------------------------------------
  // Operand kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OFD_ORD_SRC_DST,
    OFD_ORD_DST_SRC,
    OFD_ORD_NONE
  } ofd_order_t;

  typedef enum logic [3:0] {
    OFD_K_NONE,
    OFD_K_REG,
    OFD_K_WORK,
    OFD_K_PAIR,
    OFD_K_WPAIR,
    OFD_K_EXT,
    OFD_K_IMM,
    OFD_K_REL,
    OFD_K_IDX,
    OFD_K_BIT,
    OFD_K_VEC,
    OFD_K_ABS
  } ofd_kind_t;

endpackage

// >>> rtl/ofd_order_rom.sv
// Per-opcode operand order lookup for the operand field decoder.
// Assumes purely combinational use from the same clock domain.
`timescale 1ns/100ps
module ofd_order_rom
  import ofd_pkg::*;
(
  // Opcode in
  input wire logic [7:0] opcode,
  // Lookup results
  output ofd_order_t order,
  output logic [1:0] op_len
);

  // --------------------------------------------------------------
  // Table
  // --------------------------------------------------------------
  // Only known encodings are listed; others report no operands
  always_comb begin
    order = OFD_ORD_NONE;
    op_len = OFD_LEN_ZERO;
    case (opcode)
      OFD_OPC_ADD_RR: begin
        order = OFD_ORD_SRC_DST;
        op_len = OFD_LEN_TWO;
      end
      default: begin
        order = OFD_ORD_NONE;
        op_len = OFD_LEN_ZERO;
      end
    endcase
  end

endmodule

// >>> rtl/ofd_decoder.sv
// Operand field decoder: takes fetched instruction bytes and presents
// decoded operands, operand arithmetic and the add datapath result.
// Assumes bytes arrive on the core clock with a valid strobe.
`timescale 1ns/100ps
module ofd_decoder
  import ofd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Instruction byte stream
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [15:0] next_pc,
  // Generic operand helpers
  input wire logic [7:0] index_base,
  input wire logic [7:0] field_byte,
  input wire logic [11:0] ext_field,
  input wire logic [15:0] abs_field,
  // Operand values read from the register file
  input wire logic [7:0] src_value,
  input wire logic [7:0] dst_value,
  // Decoded instruction
  output logic instr_valid,
  output logic [7:0] opcode,
  output logic [7:0] src_addr,
  output logic [7:0] dst_addr,
  output logic src_is_working,
  output logic dst_is_working,
  output logic [3:0] src_work_reg,
  output logic [3:0] dst_work_reg,
  // Decoded auxiliary fields
  output logic [15:0] branch_target,
  output logic [7:0] indexed_addr,
  output logic [7:0] pair_addr,
  output logic [3:0] working_pair_operand,
  output logic [11:0] extended_register_operand,
  output logic [15:0] absolute_jump_target,
  output logic [2:0] bit_select,
  output logic [7:0] immediate_operand,
  output logic polarity,
  output logic [7:0] trap_vector,
  // Add datapath
  output logic add_wr_en,
  output logic [7:0] add_wr_addr,
  output logic [7:0] add_wr_data
);

  // --------------------------------------------------------------
  // Fetch sequencing
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    OFD_S_OPC,
    OFD_S_B1,
    OFD_S_B2
  } ofd_state_t;

  ofd_state_t state_q;
  logic [7:0] opc_q;
  logic [7:0] b1_q;
  ofd_order_t order;
  logic [1:0] op_len;

  ofd_order_rom u_rom (
    .opcode(state_q == OFD_S_OPC ? byte_data : opc_q),
    .order(order),
    .op_len(op_len)
  );

  // State machine walks opcode then operand bytes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= OFD_S_OPC;
    end else if (byte_valid) begin
      case (state_q)
        OFD_S_OPC: begin
          // Unknown opcodes finish at once; no operand bytes taken
          if (op_len != OFD_LEN_ZERO) begin
            state_q <= OFD_S_B1;
          end
        end
        OFD_S_B1: begin
          state_q <= (op_len == OFD_LEN_TWO) ? OFD_S_B2 : OFD_S_OPC;
        end
        OFD_S_B2: begin
          state_q <= OFD_S_OPC;
        end
        default: begin
          state_q <= OFD_S_OPC;
        end
      endcase
    end
  end

  // Byte capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      opc_q <= OFD_RESET_BYTE;
      b1_q <= OFD_RESET_BYTE;
    end else if (byte_valid) begin
      if (state_q == OFD_S_OPC) begin
        opc_q <= byte_data;
      end
      if (state_q == OFD_S_B1) begin
        b1_q <= byte_data;
      end
    end
  end

  // --------------------------------------------------------------
  // Source and destination placement
  // --------------------------------------------------------------
  logic done;
  logic [7:0] src_byte;
  logic [7:0] dst_byte;

  assign done = byte_valid && (state_q == OFD_S_B2);

  // Order comes from the table, so other encodings slot in later
  always_comb begin
    if (order == OFD_ORD_DST_SRC) begin
      src_byte = byte_data;
      dst_byte = b1_q;
    end else begin
      src_byte = b1_q;
      dst_byte = byte_data;
    end
  end

  // --------------------------------------------------------------
  // Escape decode, one slot per operand
  // --------------------------------------------------------------
  // Slot 0 is the source and slot 1 the destination; one shared
  // decode keeps the two operands from ever disagreeing on escape.
  logic [7:0] slot_byte [2];
  logic slot_esc [2];
  logic [3:0] slot_reg [2];

  // Slots fed from the placement above
  assign slot_byte[0] = src_byte;
  assign slot_byte[1] = dst_byte;

  for (genvar g = 0; g < 2; g++) begin : g_slot
    // Upper nibble E marks the escaped form of a register byte
    assign slot_esc[g] = slot_byte[g][7:4] == OFD_ESC_NIBBLE;
    // Low nibble then names the working register, 0 to 15
    assign slot_reg[g] = slot_byte[g][3:0];
  end

  // --------------------------------------------------------------
  // Decoded instruction registers
  // --------------------------------------------------------------
  // Decode strobe: one pulse per instruction whose second operand byte is taken
  always_ff @(posedge clk) begin
    if (!rstn) begin
      instr_valid <= 1'h0;
    end else begin
      instr_valid <= done;
    end
  end

  // Opcode and raw addresses stand until the next decode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      opcode <= OFD_RESET_BYTE;
      src_addr <= OFD_RESET_BYTE;
      dst_addr <= OFD_RESET_BYTE;
    end else if (done) begin
      opcode <= opc_q;
      // Full byte kept, so all 256 file locations stay reachable
      src_addr <= src_byte;
      dst_addr <= dst_byte;
    end
  end

  // Working register view of both operands
  always_ff @(posedge clk) begin
    if (!rstn) begin
      src_is_working <= 1'h0;
      dst_is_working <= 1'h0;
      src_work_reg <= OFD_RESET_NIB;
      dst_work_reg <= OFD_RESET_NIB;
    end else if (done) begin
      src_is_working <= slot_esc[0];
      dst_is_working <= slot_esc[1];
      src_work_reg <= slot_reg[0];
      dst_work_reg <= slot_reg[1];
    end
  end

  // --------------------------------------------------------------
  // Auxiliary operand fields
  // --------------------------------------------------------------
  // These follow the helper inputs every cycle; the core picks the
  // field that its opcode needs, so no qualifier is registered.
  logic [15:0] rel_sext;
  logic [7:0] idx_sum;

  // Sign extension keeps -128..+127 reach in both directions
  assign rel_sext = {{8{field_byte[7]}}, field_byte};
  // Eight-bit wrap is intended; the register space is 256 bytes
  assign idx_sum = 8'(index_base + field_byte);

  // Relative branch: next address plus the signed displacement
  always_ff @(posedge clk) begin
    if (!rstn) begin
      branch_target <= OFD_RESET_ADDR16;
    end else begin
      // Sixteen-bit wrap matches the program address space
      branch_target <= 16'(next_pc + rel_sext);
    end
  end

  // Indexed register or pair address
  always_ff @(posedge clk) begin
    if (!rstn) begin
      indexed_addr <= OFD_RESET_BYTE;
    end else begin
      indexed_addr <= idx_sum;
    end
  end

  // Low bit forced clear: pairs sit on even addresses only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pair_addr <= OFD_RESET_BYTE;
      working_pair_operand <= OFD_RESET_NIB;
    end else begin
      pair_addr <= {field_byte[7:1], 1'h0};
      working_pair_operand <= {field_byte[3:1], 1'h0};
    end
  end

  // Wide address operands pass straight through
  always_ff @(posedge clk) begin
    if (!rstn) begin
      extended_register_operand <= OFD_RESET_ADDR12;
      absolute_jump_target <= OFD_RESET_ADDR16;
    end else begin
      extended_register_operand <= ext_field;
      absolute_jump_target <= abs_field;
    end
  end

  // Bit position and bit sense
  // Limitation: both share one byte, so a caller that needs both
  // must pack them into field_byte together
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bit_select <= OFD_RESET_BIT;
      polarity <= 1'h0;
    end else begin
      bit_select <= field_byte[6:4];
      polarity <= field_byte[0];
    end
  end

  // Whole-byte operands
  always_ff @(posedge clk) begin
    if (!rstn) begin
      immediate_operand <= OFD_RESET_BYTE;
      trap_vector <= OFD_RESET_BYTE;
    end else begin
      immediate_operand <= field_byte;
      trap_vector <= field_byte;
    end
  end

  // --------------------------------------------------------------
  // Add datapath
  // --------------------------------------------------------------
  // Write strobe: only an add that has just decoded writes back
  always_ff @(posedge clk) begin
    if (!rstn) begin
      add_wr_en <= 1'h0;
    end else begin
      add_wr_en <= instr_valid && (opcode == OFD_OPC_ADD_RR);
    end
  end

  // Address and sum use the values read in the decode cycle
  // Carry out is dropped: flags are not produced by this block
  always_ff @(posedge clk) begin
    if (!rstn) begin
      add_wr_addr <= OFD_RESET_BYTE;
      add_wr_data <= OFD_RESET_BYTE;
    end else begin
      add_wr_addr <= dst_addr;
      add_wr_data <= 8'(dst_value + src_value);
    end
  end

endmodule

// >>> tb/ofd_properties.sv
// Concurrent checks on the operand field decoder ports.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/100ps
module ofd_properties
  import ofd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Inputs seen by the decoder
  input wire logic [15:0] next_pc,
  input wire logic [7:0] index_base,
  input wire logic [7:0] field_byte,
  input wire logic [7:0] src_value,
  input wire logic [7:0] dst_value,
  // Decoded results
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_addr,
  input wire logic [15:0] branch_target,
  input wire logic [7:0] indexed_addr,
  input wire logic [7:0] pair_addr,
  input wire logic [3:0] working_pair_operand,
  input wire logic [2:0] bit_select,
  input wire logic polarity,
  input wire logic [7:0] immediate_operand,
  input wire logic [7:0] trap_vector,
  // Add write-back
  input wire logic add_wr_en,
  input wire logic [7:0] add_wr_addr,
  input wire logic [7:0] add_wr_data
);
  // Fields lag one edge, so checks wait one edge out of reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rel_target: assert property ($past(rstn) |->
    branch_target == $past(next_pc) + 16'(signed'($past(field_byte))))
    else $error("bad branch target");
  a_idx_sum: assert property ($past(rstn) |->
    indexed_addr == 8'($past(index_base) + $past(field_byte)))
    else $error("bad indexed address");
  a_pair_even: assert property ($past(rstn) |->
    pair_addr == ($past(field_byte) & 8'hFE)) else $error("bad pair");
  a_wpair_even: assert property ($past(rstn) |->
    working_pair_operand == 4'($past(field_byte) & 8'h0E))
    else $error("bad working pair");
  a_bit_pol: assert property ($past(rstn) |->
    bit_select == 3'($past(field_byte) >> 4) &&
    polarity == 1'($past(field_byte))) else $error("bad bit fields");
  a_imm_vec: assert property ($past(rstn) |->
    immediate_operand == $past(field_byte) &&
    trap_vector == $past(field_byte)) else $error("bad byte fields");
  a_add_write: assert property (add_wr_en |->
    $past(instr_valid) && $past(opcode) == OFD_OPC_ADD_RR &&
    add_wr_addr == $past(dst_addr) &&
    add_wr_data == 8'($past(src_value) + $past(dst_value)))
    else $error("bad add write");
  a_valid_pulse: assert property (instr_valid |=>
    !instr_valid && add_wr_en == (opcode == OFD_OPC_ADD_RR))
    else $error("bad decode pulse");
  // Main traffic seen at least once
  c_decode: cover property (instr_valid);
  c_add: cover property (instr_valid ##1 add_wr_en);
  c_neg_disp: cover property (field_byte[7]);
endmodule

bind ofd_decoder ofd_properties u_props (.*);

// >>> tb/ofd_fetch_model.sv
// Fetch path model: hands instruction bytes to the decoder.
// Assumes one caller process and the decoder's core clock.
`timescale 1ns/100ps
module ofd_fetch_model (
  // Clock in, byte stream out
  input wire logic clk,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  // Quiet until the first byte
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  // Idle data flips each cycle so a stale byte is never mistaken
  task automatic rel();
    @(posedge clk);
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
  endtask
  // Byte after gap idle cycles, held until the edge that takes it
  task automatic put(input logic [7:0] b, input int gap);
    repeat (gap) rel();
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data <= b;
  endtask
endmodule

// >>> tb/tb.sv
// Random and corner tests of the operand field decoder.
// Assumes the fetch model drives bytes and the bench the rest.
`timescale 1ns/100ps
module tb;
  import ofd_pkg::*;
  logic clk, byte_valid, instr_valid, polarity, add_wr_en, src_is_working;
  logic dst_is_working, rstn = 1'b0;
  logic [15:0] next_pc = 16'h0000, abs_field = 16'h0000;
  logic [15:0] branch_target, absolute_jump_target;
  logic [11:0] ext_field = 12'h000, extended_register_operand;
  logic [7:0] index_base = 8'h00, field_byte = 8'h00, s, d;
  logic [7:0] src_value = 8'h00, dst_value = 8'h00, byte_data, opcode;
  logic [7:0] src_addr, dst_addr, indexed_addr, pair_addr, trap_vector;
  logic [7:0] immediate_operand, add_wr_addr, add_wr_data;
  logic [3:0] src_work_reg, dst_work_reg, working_pair_operand;
  logic [2:0] bit_select;
  int err_count = 0, num_checks = 0;
  // Corners: displacement ends and byte ends; plain and escaped sources
  logic [7:0] cs [4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};
  logic [7:0] ss [4] = '{8'h08, 8'hE8, 8'hFF, 8'hEF};
  ofd_decoder dut (.*);
  ofd_fetch_model u_fetch (.clk, .byte_valid, .byte_data);
  // Core clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Next address plus the sign-extended displacement
  function automatic logic [15:0] exp_br(logic [15:0] pc, logic [7:0] x);
    return pc + {{8{x[7]}}, x};
  endfunction
  // Sum as the destination receives it, carry dropped
  function automatic logic [7:0] exp_sum(logic [7:0] a, logic [7:0] b);
    return 8'(a + b);
  endfunction
  // One add through the fetch model, then decode and write-back checks
  task automatic run_add(input logic [7:0] sb, input logic [7:0] db,
    input int g);
    int k;
    src_value <= 8'($urandom);
    dst_value <= 8'($urandom);
    u_fetch.put(OFD_OPC_ADD_RR, 0);
    u_fetch.put(sb, g);
    u_fetch.put(db, 0);
    u_fetch.rel();
    #1;
    for (k = 0; k < 8 && instr_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 8) begin
      err_count++;
      wrap_up();
    end
    chk(16'(src_is_working), 16'(sb[7:4] == OFD_ESC_NIBBLE));
    if (sb[7:4] == OFD_ESC_NIBBLE)
      chk(16'(src_work_reg), 16'(sb[3:0]));
    else
      chk(16'(src_addr), 16'(sb));
    chk(16'(dst_is_working), 16'(db[7:4] == OFD_ESC_NIBBLE));
    if (db[7:4] == OFD_ESC_NIBBLE)
      chk(16'(dst_work_reg), 16'(db[3:0]));
    chk(16'(dst_addr), 16'(db));
    chk(16'(opcode), 16'(OFD_OPC_ADD_RR));
    @(posedge clk);
    #1;
    chk(16'(add_wr_en), 16'h0001);
    chk(16'(add_wr_addr), 16'(db));
    chk(16'(add_wr_data), 16'(exp_sum(src_value, dst_value)));
  endtask
  // Reset, field stream with corners first, then add traffic
  initial begin
    void'($urandom(82));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      next_pc <= 16'($urandom);
      index_base <= 8'($urandom);
      field_byte <= (i < 4) ? cs[i] : 8'($urandom);
      ext_field <= 12'($urandom);
      abs_field <= 16'($urandom);
      @(posedge clk);
      #1;
      chk(branch_target, exp_br(next_pc, field_byte));
      chk(16'(extended_register_operand), 16'(ext_field));
      chk(absolute_jump_target, abs_field);
    end
    $display("field test done");
    for (int i = 0; i < 12; i++) begin
      s = (i < 4) ? ss[i] : 8'($urandom);
      d = (i < 4) ? cs[i] : 8'($urandom);
      @(posedge clk);
      u_fetch.put(8'h0F, i % 3); // Stray opcode takes one byte only
      run_add(s, d, i % 2);
    end
    $display("add test done");
    // Reset lands with an add half fetched; the next add starts clean
    u_fetch.put(OFD_OPC_ADD_RR, 1);
    u_fetch.put(8'hE3, 0);
    u_fetch.rel();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(16'({instr_valid, add_wr_en}), 16'h0000);
    chk(16'(dst_addr), 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    run_add(8'hEF, 8'hE0, 1);
    $display("reset test done");
    wrap_up();
  end
endmodule
